// *** bench/bus_src_model.sv ***
// partner model: bus clock source and peer data driver
`timescale 1ns/100ps
`default_nettype none
module bus_src_model (
   input wire logic [7:0] rx_addr_i, // slot carrying the test bit
   input wire logic [7:0] echo_addr_i, // slot where echo is looked at
   input wire logic echo_d_i, // echo value from the node
   input wire logic echo_oe_i, // echo enable from the node
   output logic bus_clk_o, // bus clock, stands low while idle
   output logic bus_data_o // wired data line level
);
   logic drv;
   logic echo_val;
   logic echo_oe;
   // pulled-down line: any driven one wins, as on the real wire
   assign bus_data_o = drv | (echo_oe_i & echo_d_i);
   initial begin
      bus_clk_o = 1'b0;
      drv = 1'b0;
      echo_val = 1'b0;
      echo_oe = 1'b0;
   end
   // sync with optional check pulse, then eight clocked slots
   task automatic frame(input logic bitv, input logic pulse);
      drv = 1'b0;
      // pulse after the node's 200 ns sync start; odd delay skews phase
      #251;
      drv = pulse;
      #60;
      drv = 1'b0;
      #90;
      for (int a = 0; a < 8; a++) begin
         // other slots carry the inverse so a stale value never matches
         drv = (a == rx_addr_i) ? bitv : ~bitv;
         #15 bus_clk_o = 1'b1;
         #15 bus_clk_o = 1'b0;
         if (a + 1 == echo_addr_i) begin
            echo_val = echo_d_i;
            echo_oe = echo_oe_i;
         end
      end
      drv = 1'b0;
   endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the bus node supervisor
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import node_sup_pkg::*;
   typedef struct {
      logic [1:0] len;
      int ones;
      logic exp;
   } row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic bclk, bdata, dout, doe, echo_en, echo_inv, peer;
   logic src_mode, src_halt, start_ok, loss, fault, run, out;
   logic [7:0] rx_addr, echo_addr;
   logic [1:0] deb_len;
   int n_fail = 0;
   int checked = 0;
   // debounce lengths against count of one-frames; 1 acts as 3
   row_t rows[6] = '{'{DEB_OFF, 1, 1'b1}, '{DEB_LEN2, 1, 1'b0},
      '{DEB_LEN2, 2, 1'b1}, '{DEB_LEN3, 2, 1'b0},
      '{DEB_LEN3, 3, 1'b1}, '{2'h1, 2, 1'b0}};
   always #2.5 clk = ~clk;
   // short detect count keeps each loss at 1000 ns
   bus_node_sup #(.CLOSS_CYCLES(200), .SYNC_MAX_CYCLES(100), .AW(8)) dut_u (
      .CLK_I(clk), .RESET_I(rst), .BUS_CLK_I(bclk), .BUS_DATA_I(bdata),
      .BUS_DATA_O(dout), .BUS_DATA_OE_O(doe), .RX_ADDR_I(rx_addr),
      .ECHO_ADDR_I(echo_addr), .ECHO_EN_I(echo_en),
      .ECHO_INV_I(echo_inv), .PEER_MODE_I(peer), .DEB_LEN_I(deb_len),
      .SRC_MODE_I(src_mode), .SRC_HALT_I(src_halt),
      .SRC_START_OK_O(start_ok), .CLOCK_LOSS_O(loss),
      .BUS_FAULT_O(fault), .RUN_O(run), .OUT_O(out));
   bus_src_model src_u (.rx_addr_i(rx_addr), .echo_addr_i(echo_addr),
      .echo_d_i(dout), .echo_oe_i(doe), .bus_clk_o(bclk),
      .bus_data_o(bdata));
   // compare and count
   task automatic chk(input logic seen, input logic exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
            exp);
      end
   endtask
   task automatic end_sim;
      $display("mismatches %0d comparisons %0d", n_fail, checked);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic frames(input int n, input logic b);
      repeat (n) src_u.frame(b, 1'b1);
      @(negedge clk);
   endtask
   // idle well past the detect time
   task automatic lose;
      #1100;
      @(negedge clk);
   endtask
   // hang guard
   initial begin
      #200000;
      n_fail++;
      end_sim();
   end
   initial begin
      {echo_en, echo_inv, peer, src_mode, src_halt} = 5'h00;
      rx_addr = 8'h02;
      echo_addr = 8'h05;
      deb_len = DEB_OFF;
      repeat (16) @(posedge clk);
      @(negedge clk);
      chk(loss, 1'b1);
      chk(run, 1'b0);
      chk(out, SHELF_VAL);
      chk(doe, 1'b0);
      rst = 1'b0;
      repeat (8) @(negedge clk);
      // table of debounce cases, each from a fresh bus start
      foreach (rows[i]) begin
         lose();
         deb_len = rows[i].len;
         // first frame starts init, its sync is not counted
         frames(5, 1'b0);
         chk(run, 1'b0);
         frames(1, 1'b0);
         chk(run, 1'b1);
         frames(1, 1'b0);
         chk(out, DEB_DEFAULT);
         frames(rows[i].ones, 1'b1);
         frames(1, 1'b0);
         chk(out, rows[i].exp);
      end
      // echo in both polarities, held back early in init
      deb_len = DEB_OFF;
      echo_en = 1'b1;
      for (int v = 0; v < 2; v++) begin
         lose();
         echo_inv = v[0];
         frames(2, 1'b0);
         chk(src_u.echo_oe, 1'b0);
         frames(4, 1'b1);
         chk(src_u.echo_oe, 1'b1);
         chk(src_u.echo_val, v[0] ^ 1'b1);
         frames(1, 1'b0);
         chk(src_u.echo_val, v[0]);
      end
      echo_en = 1'b0;
      frames(1, 1'b1);
      chk(src_u.echo_oe, 1'b0);
      // same slot: allowed master/slave, refused peer-to-peer
      echo_en = 1'b1;
      // slot 6: config needs four link edges after each sync clear
      echo_inv = 1'b1;
      rx_addr = 8'h06;
      echo_addr = 8'h06;
      frames(2, 1'b1);
      chk(src_u.echo_oe, 1'b1);
      // own slot's bit not yet taken: echo carries inverted default
      chk(src_u.echo_val, 1'b1);
      peer = 1'b1;
      frames(2, 1'b1);
      chk(src_u.echo_oe, 1'b0);
      peer = 1'b0;
      echo_inv = 1'b0;
      rx_addr = 8'h02;
      echo_addr = 8'h05;
      // loss timing and clock source permission
      src_mode = 1'b1;
      frames(1, 1'b1);
      chk(start_ok, 1'b0);
      #800;
      @(negedge clk);
      chk(loss, 1'b0);
      chk(out, 1'b1);
      #300;
      @(negedge clk);
      chk(loss, 1'b1);
      chk(out, SHELF_VAL);
      chk(run, 1'b0);
      chk(doe, 1'b0);
      chk(start_ok, 1'b1);
      src_halt = 1'b1;
      @(negedge clk);
      chk(start_ok, 1'b0);
      {src_mode, src_halt} = 2'h0;
      // first edge ends loss; idle during init restarts the count
      frames(1, 1'b1);
      chk(loss, 1'b0);
      frames(2, 1'b1);
      lose();
      chk(loss, 1'b1);
      frames(3, 1'b1);
      chk(run, 1'b0);
      chk(out, SHELF_VAL);
      frames(4, 1'b1);
      chk(run, 1'b1);
      chk(out, 1'b1);
      // sync without check pulse
      src_u.frame(1'b1, 1'b0);
      @(negedge clk);
      chk(fault, 1'b1);
      chk(out, SHELF_VAL);
      chk(run, 1'b0);
      frames(1, 1'b1);
      chk(fault, 1'b0);
      // reset during init after the fault, then a fresh bus start
      rst = 1'b1;
      repeat (16) @(negedge clk);
      chk(loss, 1'b1);
      chk(out, SHELF_VAL);
      chk(doe, 1'b0);
      rst = 1'b0;
      @(negedge clk);
      frames(1, 1'b1);
      chk(loss, 1'b0);
      chk(run, 1'b0);
      end_sim();
   end
endmodule
`default_nettype wire

// *** hdl/bit_debounce.sv ***
// per-channel frame debounce of received single-bit signals
`timescale 1ns/100ps
`default_nettype none
module bit_debounce
   import node_sup_pkg::*;
#(
   parameter int NCH = 1
) (
   input wire logic clk_i, // local clock
   input wire logic rst_i, // synchronous reset
   input wire logic clr_i, // back to default (bus init)
   input wire logic [1:0] len_i, // 0 off, 2 or 3 frames
   input wire logic stb_i, // one pulse per valid frame
   input wire logic [NCH-1:0] bit_i, // received values
   output logic [NCH-1:0] val_o // debounced values
);
   typedef struct packed {
      logic [NCH-1:0] h0;
      logic [NCH-1:0] h1;
      logic [NCH-1:0] val;
   } deb_t;
   deb_t q, d;

   // history of the last two frames per channel
   always_comb begin
      d = q;
      if (clr_i) begin
         d.h0 = {NCH{DEB_DEFAULT}};
         d.h1 = {NCH{DEB_DEFAULT}};
         d.val = {NCH{DEB_DEFAULT}};
      end else if (stb_i) begin
         d.h0 = bit_i;
         d.h1 = q.h0;
         for (int i = 0; i < NCH; i++) begin
            // change only after the full length of equal frames
            if (len_i == DEB_OFF) begin
               d.val[i] = bit_i[i];
            end else if (len_i == DEB_LEN2) begin
               if (bit_i[i] == q.h0[i]) d.val[i] = bit_i[i];
            end else if (bit_i[i] == q.h0[i] && bit_i[i] == q.h1[i]) begin
               d.val[i] = bit_i[i];
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '{h0: {NCH{DEB_DEFAULT}}, h1: {NCH{DEB_DEFAULT}},
                val: {NCH{DEB_DEFAULT}}};
      end else begin
         q <= d;
      end
   end

   assign val_o = q.val;
endmodule
`default_nettype wire

// *** hdl/bus_node_sup.sv ***
// bus node supervisor: clock loss, init count, debounce and echo
`timescale 1ns/100ps
`default_nettype none
module bus_node_sup
   import node_sup_pkg::*;
#(
   parameter int CLOSS_CYCLES = CLOSS_CYC, // clock loss detect count
   parameter int SYNC_MAX_CYCLES = SYNC_MAX_CYC, // longest sync pause
   parameter int AW = 8 // bus address width
) (
   input wire logic CLK_I, // local clock, 200 MHz
   input wire logic RESET_I, // synchronous, active high
   input wire logic BUS_CLK_I, // bus clock line, link domain
   input wire logic BUS_DATA_I, // bus data line level
   output logic BUS_DATA_O, // echo bit to drive
   output logic BUS_DATA_OE_O, // high while driving data
   input wire logic [AW-1:0] RX_ADDR_I, // address of received bit
   input wire logic [AW-1:0] ECHO_ADDR_I, // address of echo slot
   input wire logic ECHO_EN_I, // echo enable
   input wire logic ECHO_INV_I, // invert echoed value
   input wire logic PEER_MODE_I, // peer-to-peer mode
   input wire logic [1:0] DEB_LEN_I, // 0 off, 2 or 3 frames
   input wire logic SRC_MODE_I, // node acts as clock source
   input wire logic SRC_HALT_I, // source asked to stay halted
   output logic SRC_START_OK_O, // source may start the bus
   output logic CLOCK_LOSS_O, // clock loss condition
   output logic BUS_FAULT_O, // last sync lacked check pulse
   output logic RUN_O, // normal operation
   output logic OUT_O // external output, shelf when off
);
   localparam int CW = $clog2(CLOSS_CYCLES + 1);
   localparam logic [CW-1:0] CLOSS_END = CW'(CLOSS_CYCLES);
   localparam logic [CW-1:0] SYNC_BEG = CW'(SYNC_MIN_CYC);
   localparam logic [CW-1:0] SYNC_CLR_END = CW'(SYNC_MIN_CYC + CLR_CYC);
   localparam logic [CW-1:0] SYNC_LONG = CW'(SYNC_MAX_CYCLES);

   typedef struct packed {
      node_state_t st;
      logic [CW-1:0] idle;
      logic clk_prev;
      logic dat_prev;
      logic in_sync;
      logic chk_seen;
      logic fault;
      logic [2:0] nsync;
      logic frame_stb;
      logic deb_clr;
      logic addr_clr;
      logic long_pause;
      logic rx_hold;
      logic out;
   } loc_t;

   typedef struct packed {
      logic [AW-1:0] addr;
      logic rx_bit;
      logic drv;
      logic dout;
   } lnk_t;

   loc_t q, d;
   lnk_t lq, ld;
   logic [1:0] pins_s;
   logic [4:0] cfg_s;
   logic rx_bit_s;
   logic deb_val;
   logic clk_edge;
   logic dat_rise;
   logic tx_ok;
   logic same_addr;

   // bus clock and data lines sampled into the local domain
   level_sync #(.W(2)) u_pin_sync (
      .clk_i(CLK_I),
      .arst_i(1'b0),
      .d_i({BUS_CLK_I, BUS_DATA_I}),
      .q_o(pins_s)
   );

   // received bit, held until the sync clear, into local domain
   level_sync #(.W(1)) u_rx_sync (
      .clk_i(CLK_I),
      .arst_i(1'b0),
      .d_i(lq.rx_bit),
      .q_o(rx_bit_s)
   );

   // configuration and send permission into the link domain
   level_sync #(.W(5)) u_cfg_sync (
      .clk_i(BUS_CLK_I),
      .arst_i(q.addr_clr),
      .d_i({ECHO_EN_I, ECHO_INV_I, PEER_MODE_I, tx_ok, 1'b1}),
      .q_o(cfg_s)
   );

   bit_debounce #(.NCH(1)) u_deb (
      .clk_i(CLK_I),
      .rst_i(RESET_I),
      .clr_i(q.deb_clr),
      .len_i(DEB_LEN_I),
      .stb_i(q.frame_stb),
      .bit_i(q.rx_hold),
      .val_o(deb_val)
   );

   assign clk_edge = pins_s[1] != q.clk_prev;
   assign dat_rise = pins_s[0] && !q.dat_prev;
   assign tx_ok = q.st != ST_LOSS && q.nsync >= IN_SYNCS;

   // local supervision: idle timer, sync periods, init count
   always_comb begin
      d = q;
      d.clk_prev = pins_s[1];
      d.dat_prev = pins_s[0];
      d.frame_stb = 1'b0;
      d.deb_clr = 1'b0;
      // timer restarts on every agreed clock-line edge
      if (clk_edge) begin
         d.idle = '0;
      end else if (q.idle != CLOSS_END) begin
         d.idle = q.idle + 1'b1;
      end
      if (q.in_sync && dat_rise) begin
         d.chk_seen = 1'b1;
      end
      // no sync period during loss, else the first frame counts twice
      if (!clk_edge && d.idle == SYNC_BEG && q.st != ST_LOSS) begin
         d.in_sync = 1'b1;
         d.chk_seen = 1'b0;
         // last frame's bit, taken before the link clear wipes it
         d.rx_hold = rx_bit_s;
      end
      if (!clk_edge && d.idle == SYNC_LONG) begin
         d.long_pause = 1'b1;
      end
      // link address cleared briefly at sync start, clock is still
      d.addr_clr = d.idle >= SYNC_BEG && d.idle < SYNC_CLR_END;
      if (clk_edge) begin
         d.long_pause = 1'b0;
         if (q.st == ST_LOSS) begin
            d.st = ST_INIT;
            d.nsync = '0;
            d.fault = 1'b0;
            d.deb_clr = 1'b1;
         end else if (q.in_sync) begin
            d.in_sync = 1'b0;
            if (q.chk_seen || dat_rise) begin
               d.frame_stb = q.st == ST_RUN;
               d.fault = 1'b0;
               if (q.nsync != OUT_SYNCS) begin
                  d.nsync = q.nsync + 1'b1;
               end
               if (d.nsync == OUT_SYNCS) begin
                  d.st = ST_RUN;
               end
            end else begin
               // missing check pulse: shelf now, init again
               d.fault = 1'b1;
               d.st = ST_INIT;
               d.nsync = '0;
               d.deb_clr = 1'b1;
            end
         end
      end else if (d.idle == CLOSS_END && q.st != ST_LOSS) begin
         // also covers a stall during init, never reaching run
         d.st = ST_LOSS;
         d.nsync = '0;
         d.in_sync = 1'b0;
      end
      d.out = d.st == ST_RUN ? deb_val : SHELF_VAL;
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         q <= '{st: ST_LOSS, idle: '0, clk_prev: 1'b0, dat_prev: 1'b0,
                in_sync: 1'b0, chk_seen: 1'b0, fault: 1'b0,
                nsync: '0, frame_stb: 1'b0, deb_clr: 1'b0,
                addr_clr: 1'b1, long_pause: 1'b0, rx_hold: DEB_DEFAULT,
                out: SHELF_VAL};
      end else begin
         q <= d;
      end
   end

   // peer mode forbids echo onto the received address
   assign same_addr = ECHO_ADDR_I == RX_ADDR_I;

   // link side: address count, receive capture and echo drive
   always_comb begin
      ld = lq;
      ld.addr = lq.addr + 1'b1;
      if (lq.addr == RX_ADDR_I) begin
         ld.rx_bit = BUS_DATA_I;
      end
      // master/slave may reuse the address, slots are split in time
      ld.drv = cfg_s[0] && cfg_s[4] && cfg_s[1]
         && ld.addr == ECHO_ADDR_I
         && !(cfg_s[2] && same_addr);
      ld.dout = cfg_s[3] ^ ld.rx_bit;
      if (!ld.drv) begin
         ld.dout = 1'b0;
      end
   end

   // cleared while the bus clock is still, by a local flip-flop
   always_ff @(posedge BUS_CLK_I or posedge q.addr_clr) begin
      if (q.addr_clr) begin
         lq <= '{addr: ADDR_RESET, rx_bit: DEB_DEFAULT, drv: 1'b0,
                 dout: 1'b0};
      end else begin
         lq <= ld;
      end
   end

   // echo held off once loss is seen, so a source stops its data
   assign BUS_DATA_O = lq.dout;
   assign BUS_DATA_OE_O = lq.drv && q.st != ST_LOSS;
   // start only after a full detect time of silence
   assign SRC_START_OK_O = SRC_MODE_I && !SRC_HALT_I
      && q.long_pause && q.idle == CLOSS_END;
   assign CLOCK_LOSS_O = q.st == ST_LOSS;
   assign BUS_FAULT_O = q.fault;
   assign RUN_O = q.st == ST_RUN;
   assign OUT_O = q.out;

   sequence s_idle_full;
      !clk_edge && q.idle == CLOSS_END - 1'b1;
   endsequence
   sequence s_sync_no_check;
      clk_edge && q.in_sync && !q.chk_seen && !dat_rise;
   endsequence

   property p_loss_detect;
      @(posedge CLK_I) disable iff (RESET_I)
      s_idle_full |=> CLOCK_LOSS_O;
   endproperty
   a_loss_detect: assert property (p_loss_detect)
      else $error("clock loss not declared after idle time");

   property p_loss_shelf;
      @(posedge CLK_I) disable iff (RESET_I)
      CLOCK_LOSS_O ##1 CLOCK_LOSS_O |-> OUT_O == SHELF_VAL;
   endproperty
   a_loss_shelf: assert property (p_loss_shelf)
      else $error("output not shelved during clock loss");

   property p_edge_init;
      @(posedge CLK_I) disable iff (RESET_I)
      CLOCK_LOSS_O && clk_edge |=> q.st == ST_INIT && q.nsync == 3'h0;
   endproperty
   a_edge_init: assert property (p_edge_init)
      else $error("first clock edge did not start init");

   property p_init_no_run;
      @(posedge CLK_I) disable iff (RESET_I)
      (q.st == ST_INIT) and s_idle_full |=> !RUN_O [*2];
   endproperty
   a_init_no_run: assert property (p_init_no_run)
      else $error("reached run after idle during init");

   property p_start_wait;
      @(posedge CLK_I) disable iff (RESET_I)
      $rose(SRC_START_OK_O) |-> $past(q.idle) >= CLOSS_END - 1'b1
         && !clk_edge;
   endproperty
   a_start_wait: assert property (p_start_wait)
      else $error("source start allowed too early");

   property p_run_count;
      @(posedge CLK_I) disable iff (RESET_I)
      $rose(RUN_O) |-> q.nsync == OUT_SYNCS && $past(q.in_sync);
   endproperty
   a_run_count: assert property (p_run_count)
      else $error("run entered before five valid syncs");

   property p_fault_shelf;
      @(posedge CLK_I) disable iff (RESET_I)
      s_sync_no_check |=> BUS_FAULT_O && OUT_O == SHELF_VAL && !RUN_O;
   endproperty
   a_fault_shelf: assert property (p_fault_shelf)
      else $error("missing check pulse did not shelve outputs");

   property p_deb_frame;
      @(posedge CLK_I) disable iff (RESET_I)
      RUN_O && $past(RUN_O) && $changed(OUT_O) |-> $past(q.frame_stb, 2);
   endproperty
   a_deb_frame: assert property (p_deb_frame)
      else $error("output changed without a frame");

   property p_peer_echo;
      @(posedge BUS_CLK_I) disable iff (q.addr_clr)
      lq.drv |-> !(cfg_s[2] && same_addr) && cfg_s[1];
   endproperty
   a_peer_echo: assert property (p_peer_echo)
      else $error("echo on own address or before init");

   property p_loss_timer;
      @(posedge CLK_I) disable iff (RESET_I)
      $rose(CLOCK_LOSS_O) |-> q.idle == CLOSS_END;
   endproperty
   a_loss_timer: assert property (p_loss_timer)
      else $error("loss state without full idle timer");
endmodule
`default_nettype wire

// *** hdl/level_sync.sv ***
// three-stage synchroniser; a change counts once stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module level_sync
   import node_sup_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk_i, // destination clock
   input wire logic arst_i, // clear, constant values only
   input wire logic [W-1:0] d_i, // asynchronous levels
   output logic [W-1:0] q_o // agreed levels
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
   } sync_t;
   sync_t q, d;

   // s1 is read only by s2; the agreement looks at s2 and s3
   always_comb begin
      d = q;
      d.s1 = d_i;
      d.s2 = q.s1;
      d.s3 = q.s2;
      for (int i = 0; i < W; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.lvl[i] = q.s3[i];
         end
      end
   end

   // async clear keeps the link side defined while its clock stands still
   always_ff @(posedge clk_i or posedge arst_i) begin
      if (arst_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign q_o = q.lvl;
endmodule
`default_nettype wire

// *** pkg/node_sup_pkg.sv ***
// shared constants and types for the bus node supervisor
package node_sup_pkg;
   // local clock and bus timing
   localparam real CLK_PERIOD_NS = 5.0;
   localparam real CLOCK_LOSS_DETECT_TIME_MS = 1.5;
   // longest time, so rounded down
   localparam int CLOSS_CYC = int'($floor(CLOCK_LOSS_DETECT_TIME_MS *
      1.0e6 / CLK_PERIOD_NS));
   // idle time that marks a sync period (clock pause between frames)
   localparam real SYNC_MIN_NS = 200.0;
   localparam int SYNC_MIN_CYC = int'($ceil(SYNC_MIN_NS / CLK_PERIOD_NS));
   // longest legal sync period for a clock source
   localparam real SYNC_MAX_US = 100.0;
   localparam int SYNC_MAX_CYC = int'($floor(SYNC_MAX_US * 1.0e3 /
      CLK_PERIOD_NS));
   // address counter clear pulse at start of sync
   localparam int CLR_CYC = 4;
   // init: valid syncs before outputs and before echo drive
   localparam logic [2:0] OUT_SYNCS = 3'h5;
   localparam logic [2:0] IN_SYNCS = 3'h4;
   // defaults after reset
   localparam logic SHELF_VAL = 1'h0;
   localparam logic DEB_DEFAULT = 1'h0;
   localparam logic [7:0] ADDR_RESET = 8'h00;
   // debounce length encoding
   localparam logic [1:0] DEB_OFF = 2'h0;
   localparam logic [1:0] DEB_LEN2 = 2'h2;
   localparam logic [1:0] DEB_LEN3 = 2'h3;
   typedef enum logic [1:0] {
      ST_LOSS = 2'b00,
      ST_INIT = 2'b01,
      ST_RUN = 2'b10
   } node_state_t;
endpackage
